// ### src/link_startup_ctrl.sv
// Startup, sleep, wake-up and configuration-link sequencer of the serializer.
// What this block does
// - Modulation rate: clock times (1+doubling) over coefficient*divider.
// - Six-bit sawtooth divider written by the controller.
// - Remote-side sleep bit write sleeps at once, except in the woken state, which waits for its timeout.
// - Controller-side sleep write ignored, reads zero.
// - Controller side powers down only by pin.
// - Config link enable starts oscillator-clocked link.
// - Serial enable overrides config link, video locks.
// - Control channel ready only once a link exists.
// - Side select low: controller here; high: remote.
// - Autostart low: link starts with stable clock.
// - Local controller, autostart high: wait in standby.
// - After enable: lock, then send wake-up signal.
// - Remote asleep: autostart link sends wake-up.
// - Remote controller, autostart high: start asleep.
// - Wake receiver detects frame and powers up.
// - Back to sleep unless bit cleared within 5 ms.
// - Divider lives in bits 5..0 of 0x03.
`include "link_startup_params.svh"

module link_startup_ctrl #(
  parameter int WAKE_HOLD_CYCLES = `WAKE_HOLD_US * `CLK_FREQ_MHZ,
  parameter int WAKE_IDLE_CYCLES = `WAKE_IDLE_US * `CLK_FREQ_MHZ
) (
  // Clock and reset; the clock is the internal oscillator.
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Strap and power pins.
  input  wire logic       power_down_n,
  input  wire logic       autostart_select_n,
  input  wire logic       controller_side_select,
  input  wire logic       rate_doubling_pin,
  // Clocking and lock status.
  input  wire logic       lvds_clock_stable,
  input  wire logic       pll_lock,
  input  wire logic [7:0] modulation_coefficient,
  // Reverse control channel level seen by the wake-up receiver.
  input  wire logic       wake_rx,
  // Register port.
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Link control outputs.
  output logic            serial_tx_active,
  output logic            osc_select,
  output logic            wake_pulse,
  output logic            ctrl_channel_ready,
  output logic            low_power,
  output logic            mod_tick
);

  localparam int CNT_W = 17;

  link_startup_pkg::link_state_t state;
  link_startup_pkg::link_state_t next_state;

  logic [`SAWTOOTH_DIVIDER_W-1:0] sawtooth_divider;
  logic               serial_link_enable;
  logic               config_link_enable;
  logic               sleep_bit;
  logic               strap_autostart_n;
  logic               strap_side;
  logic               strap_doubling;
  logic               straps_taken;
  logic               power_down_n_prev;
  logic               wake_rx_prev;
  logic [1:0]         edge_count;
  logic [CNT_W-1:0]   idle_cnt;
  logic [CNT_W-1:0]   wake_cnt;
  logic               wake_frame;
  logic [15:0]        mod_acc;
  logic [15:0]        mod_limit;
  logic [15:0]        mod_sum;
  logic               power_down_n_rise;
  logic               strap_event;
  logic               wr_ctrl;
  logic               sleep_req;

  assign power_down_n_rise   = power_down_n && !power_down_n_prev;
  assign strap_event = power_down_n && (!straps_taken || power_down_n_rise);
  assign wr_ctrl     = reg_wr && (reg_addr == `REG_LINK_CTRL);
  // A sleep request counts only on the remote side of the link.
  assign sleep_req   = wr_ctrl && reg_wdata[`CTRL_SLEEP_BIT] && strap_side;

  ////////////////////////////////////////////////////////////////////////////////
  // Straps are caught after reset release and at each power-down release only.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      straps_taken      <= 1'b0;
      power_down_n_prev         <= 1'b0;
      strap_autostart_n <= 1'b0;
      strap_side        <= 1'b0;
      strap_doubling    <= 1'b0;
    end else begin
      power_down_n_prev <= power_down_n;
      if (strap_event) begin
        straps_taken      <= 1'b1;
        strap_autostart_n <= autostart_select_n;
        strap_side        <= controller_side_select;
        strap_doubling    <= rate_doubling_pin;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes; the startup case may preset the enables and the sleep bit.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sawtooth_divider   <= `SAWTOOTH_DIVIDER_RESET;
      serial_link_enable <= 1'b0;
      config_link_enable <= 1'b0;
      sleep_bit          <= 1'b0;
    end else if (strap_event) begin
      serial_link_enable <= !autostart_select_n;
      config_link_enable <= 1'b0;
      sleep_bit          <= autostart_select_n && controller_side_select;
    end else begin
      if (reg_wr && reg_addr == `REG_SAWTOOTH) begin
        sawtooth_divider <= reg_wdata[`SAWTOOTH_DIVIDER_W-1:0];
      end
      if (wr_ctrl) begin
        serial_link_enable <= reg_wdata[`CTRL_SERIAL_BIT];
        config_link_enable <= reg_wdata[`CTRL_CONFIG_BIT];
      end
      // The wake timeout wins over a clear in the same cycle, so state and bit agree.
      if (state == link_startup_pkg::ST_WOKEN && wake_cnt >= CNT_W'(WAKE_HOLD_CYCLES - 1)) begin
        sleep_bit <= 1'b1;
      end else if (wr_ctrl) begin
        sleep_bit <= sleep_req;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wake-up receiver: three rising edges, each within one idle window of the one before, form a frame.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_rx_prev <= 1'b1; // Idle line level, so reset never looks like a rising edge.
      edge_count   <= 2'h0;
      idle_cnt     <= '0;
    end else begin
      wake_rx_prev <= wake_rx;
      if (state != link_startup_pkg::ST_SLEEP) begin
        edge_count <= 2'h0;
        idle_cnt   <= '0;
      end else if (wake_rx && !wake_rx_prev) begin
        if (edge_count != `WAKE_EDGES) begin
          edge_count <= edge_count + 2'h1;
        end
        idle_cnt <= '0;
      end else if (idle_cnt >= CNT_W'(WAKE_IDLE_CYCLES - 1)) begin
        edge_count <= 2'h0;
      end else begin
        idle_cnt <= idle_cnt + 1'b1;
      end
    end
  end

  assign wake_frame = (edge_count == `WAKE_EDGES);

  ////////////////////////////////////////////////////////////////////////////////
  // Time spent awake after a wake frame, counted on the internal oscillator.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_cnt <= '0;
    end else if (state == link_startup_pkg::ST_WOKEN) begin
      wake_cnt <= wake_cnt + 1'b1;
    end else begin
      wake_cnt <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state of the link sequence.
  always_comb begin
    next_state = state;
    case (state)
      link_startup_pkg::ST_OFF: begin
        if (strap_event) begin
          if (!autostart_select_n) begin
            next_state = link_startup_pkg::ST_STANDBY;
          end else if (controller_side_select) begin
            next_state = link_startup_pkg::ST_SLEEP;
          end else begin
            next_state = link_startup_pkg::ST_STANDBY;
          end
        end
      end
      link_startup_pkg::ST_STANDBY: begin
        if (sleep_req) begin
          next_state = link_startup_pkg::ST_SLEEP;
        end else if (serial_link_enable && lvds_clock_stable) begin
          next_state = link_startup_pkg::ST_LOCKING;
        end else if (config_link_enable) begin
          next_state = link_startup_pkg::ST_LOCKING;
        end
      end
      link_startup_pkg::ST_SLEEP: begin
        if (wake_frame) begin
          next_state = link_startup_pkg::ST_WOKEN;
        end
      end
      link_startup_pkg::ST_WOKEN: begin
        if (!sleep_bit) begin
          next_state = link_startup_pkg::ST_STANDBY;
        end else if (wake_cnt >= CNT_W'(WAKE_HOLD_CYCLES - 1)) begin
          next_state = link_startup_pkg::ST_SLEEP;
        end
      end
      link_startup_pkg::ST_LOCKING: begin
        if (sleep_req) begin
          next_state = link_startup_pkg::ST_SLEEP;
        end else if (!serial_link_enable && !config_link_enable) begin
          next_state = link_startup_pkg::ST_STANDBY;
        end else if (pll_lock) begin
          next_state = serial_link_enable ? link_startup_pkg::ST_VIDEO
                                          : link_startup_pkg::ST_CONFIG;
        end
      end
      link_startup_pkg::ST_CONFIG: begin
        if (sleep_req) begin
          next_state = link_startup_pkg::ST_SLEEP;
        end else if (serial_link_enable) begin
          next_state = link_startup_pkg::ST_LOCKING;
        end else if (!config_link_enable || !pll_lock) begin
          next_state = link_startup_pkg::ST_STANDBY;
        end
      end
      link_startup_pkg::ST_VIDEO: begin
        if (sleep_req) begin
          next_state = link_startup_pkg::ST_SLEEP;
        end else if (!serial_link_enable) begin
          next_state = link_startup_pkg::ST_STANDBY;
        end else if (!pll_lock || !lvds_clock_stable) begin
          next_state = link_startup_pkg::ST_LOCKING;
        end
      end
      default: begin
        next_state = link_startup_pkg::ST_OFF;
      end
    endcase
    // The power-down pin is the only way the controller side reaches low power.
    if (!power_down_n) begin
      next_state = link_startup_pkg::ST_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= link_startup_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered link outputs, one cycle behind the state they reflect.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serial_tx_active   <= 1'b0;
      osc_select         <= 1'b0;
      wake_pulse         <= 1'b0;
      ctrl_channel_ready <= 1'b0;
      low_power          <= 1'b1;
    end else begin
      serial_tx_active   <= (state == link_startup_pkg::ST_VIDEO) ||
                            (state == link_startup_pkg::ST_CONFIG);
      osc_select         <= !serial_link_enable && config_link_enable;
      wake_pulse         <= (state == link_startup_pkg::ST_LOCKING) && pll_lock &&
                            next_state != link_startup_pkg::ST_LOCKING &&
                            next_state != link_startup_pkg::ST_STANDBY &&
                            next_state != link_startup_pkg::ST_SLEEP &&
                            next_state != link_startup_pkg::ST_OFF;
      ctrl_channel_ready <= (state == link_startup_pkg::ST_VIDEO) ||
                            (state == link_startup_pkg::ST_CONFIG);
      low_power          <= (state == link_startup_pkg::ST_OFF) ||
                            (state == link_startup_pkg::ST_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sawtooth step: accumulate (1+doubling) per cycle, wrap at coefficient*divider.
  // A zero divider stops the tick rather than dividing by zero.
  assign mod_limit = 16'(modulation_coefficient) * 16'(sawtooth_divider);
  assign mod_sum   = mod_acc + {15'h0000, 1'b1} + {15'h0000, strap_doubling};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mod_acc  <= 16'h0000;
      mod_tick <= 1'b0;
    end else if (mod_limit == 16'h0000 || !serial_tx_active) begin
      mod_acc  <= 16'h0000;
      mod_tick <= 1'b0;
    end else if (mod_sum >= mod_limit) begin
      mod_acc  <= mod_sum - mod_limit;
      mod_tick <= 1'b1;
    end else begin
      mod_acc  <= mod_sum;
      mod_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port: data stand in the cycle after the strobe, zero otherwise.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= `DATA_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_SAWTOOTH:    reg_rdata <= {2'h0, sawtooth_divider};
        `REG_LINK_CTRL:   reg_rdata <= {5'h00, sleep_bit, config_link_enable,
                                        serial_link_enable};
        `REG_LINK_STATUS: reg_rdata <= {1'b0, strap_doubling, strap_side,
                                        strap_autostart_n, ctrl_channel_ready,
                                        osc_select, serial_tx_active, low_power};
        default:          reg_rdata <= `DATA_ZERO;
      endcase
    end else begin
      reg_rdata <= `DATA_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencing.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_sleep_write_ignored: assert property (
    (wr_ctrl && reg_wdata[`CTRL_SLEEP_BIT] && !strap_side && !strap_event) |=> !sleep_bit)
    else $error("Sleep bit set on the controller side.");

  a_sleep_at_once: assert property (
    (sleep_req && power_down_n && (state == link_startup_pkg::ST_VIDEO ||
     state == link_startup_pkg::ST_STANDBY)) |=> state == link_startup_pkg::ST_SLEEP ##1 low_power)
    else $error("Remote-side sleep write did not sleep at once.");

  a_power_down_n_forces_off: assert property (
    !power_down_n |=> state == link_startup_pkg::ST_OFF ##1 low_power && !serial_tx_active)
    else $error("Power-down pin did not stop the link.");

  a_video_override: assert property (
    (state == link_startup_pkg::ST_CONFIG && serial_link_enable && !sleep_req && power_down_n)
    |=> state == link_startup_pkg::ST_LOCKING)
    else $error("Serial enable did not override the configuration link.");

  a_ready_after_link: assert property (
    ctrl_channel_ready |-> $past(state) == link_startup_pkg::ST_VIDEO ||
                           $past(state) == link_startup_pkg::ST_CONFIG)
    else $error("Control channel ready without a link.");

  a_wake_after_lock: assert property (
    wake_pulse |-> $past(pll_lock) && $past(state) == link_startup_pkg::ST_LOCKING ##1 !wake_pulse)
    else $error("Wake-up pulse without lock.");

  a_wake_timeout: assert property (
    wake_cnt <= CNT_W'(WAKE_HOLD_CYCLES))
    else $error("Woken state outlived its window.");

  a_frame_wakes: assert property (
    (state == link_startup_pkg::ST_SLEEP && wake_frame && power_down_n)
    |=> state == link_startup_pkg::ST_WOKEN ##1 !low_power)
    else $error("Wake frame did not wake the device.");

  a_auto_start: assert property (
    (state == link_startup_pkg::ST_STANDBY && serial_link_enable && lvds_clock_stable &&
     !sleep_req && power_down_n) |=> state == link_startup_pkg::ST_LOCKING)
    else $error("Link did not start with a stable clock.");

  a_osc_for_config: assert property (
    (state == link_startup_pkg::ST_CONFIG) |-> osc_select)
    else $error("Configuration link not on the oscillator.");

  a_mod_tick_gated: assert property (
    mod_tick |-> $past(mod_limit) != 16'h0000 && $past(serial_tx_active))
    else $error("Modulation tick with no divider.");

  c_video_up:   cover property (state == link_startup_pkg::ST_VIDEO);
  c_config_up:  cover property (state == link_startup_pkg::ST_CONFIG);
  c_woken:      cover property (state == link_startup_pkg::ST_WOKEN ##1
                                state == link_startup_pkg::ST_STANDBY);
  c_resleep:    cover property (state == link_startup_pkg::ST_WOKEN ##1
                                state == link_startup_pkg::ST_SLEEP);

endmodule : link_startup_ctrl

// ### shared/link_startup_params.svh
// Register offsets, field positions, reset values and timing figures of the startup controller.
`ifndef LINK_STARTUP_PARAMS_SVH
`define LINK_STARTUP_PARAMS_SVH

`define REG_SAWTOOTH     8'h03
`define REG_LINK_CTRL    8'h04
`define REG_LINK_STATUS  8'h05

`define CTRL_SERIAL_BIT  0
`define CTRL_CONFIG_BIT  1
`define CTRL_SLEEP_BIT   2

`define SAWTOOTH_DIVIDER_W           6
`define SAWTOOTH_DIVIDER_RESET       6'h00
`define DATA_ZERO        8'h00

`define CLK_FREQ_MHZ     10
`define WAKE_HOLD_US     5000
`define WAKE_IDLE_US     200
`define WAKE_EDGES       2'h3

`endif

// ### shared/link_startup_pkg.sv
// Types shared by the serial link startup and sleep controller.
package link_startup_pkg;

  // One-hot sequencing states of the link controller.
  typedef enum logic [6:0] {
    ST_OFF     = 7'h01,
    ST_STANDBY = 7'h02,
    ST_SLEEP   = 7'h04,
    ST_WOKEN   = 7'h08,
    ST_LOCKING = 7'h10,
    ST_CONFIG  = 7'h20,
    ST_VIDEO   = 7'h40
  } link_state_t;

endpackage : link_startup_pkg

// ### dv/remote_ctrl_model.sv
// Behavioural model of the remote controller and the paired deserializer.
module remote_ctrl_model #(
  parameter int BIT_CYCLES = 10
) (
  // Clock.
  input  wire logic ref_clk,
  // Link signals.
  input  wire logic wake_pulse,
  input  wire logic link_active,
  output logic      wake_rx
);
  timeunit 1ns;
  timeprecision 1ns;

  int   wake_count;
  logic remote_asleep;

  ////////////////////////////////////////////////////////////////////////////////
  // The reverse channel idles high, as a UART line does.
  initial begin
    wake_rx = 1'b1;
    wake_count = 0;
    remote_asleep = 1'b1;
  end

  // The far end wakes on a wake-up pulse and sleeps again once the link goes quiet.
  always @(posedge ref_clk) begin
    if (wake_pulse === 1'b1) begin
      remote_asleep <= 1'b0;
    end else if (link_active !== 1'b1) begin
      remote_asleep <= 1'b1;
    end
  end

  // The deserializer side only counts wake-up pulses so the bench can see them.
  always @(posedge ref_clk) begin
    if (wake_pulse === 1'b1) begin
      wake_count <= wake_count + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One frame: start bit, data lowest bit first, stop bit; ten cycles a bit is 1 Mbps.
  task automatic send_frame(input logic [7:0] data);
    logic [9:0] bits;
    bits = {1'b1, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      wake_rx <= bits[i];
      repeat (BIT_CYCLES - 1) @(posedge ref_clk);
    end
  endtask : send_frame
endmodule : remote_ctrl_model

// ### dv/link_startup_ctrl_tb.sv
// Self-checking bench of the serial link startup and sleep controller.
module link_startup_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int HOLD = 200;
  localparam int IDLE = 60;
  localparam logic [7:0] COEF     = 8'h50;
  localparam logic [7:0] SAWTOOTH_DIVIDER_MAX = 8'h3F;

  logic       ref_clk, rst, power_down_n, autostart_select_n, controller_side_select;
  logic       rate_doubling_pin, lvds_clock_stable, pll_lock, wake_rx, reg_wr, reg_rd;
  logic [7:0] modulation_coefficient, reg_addr, reg_wdata, reg_rdata, lfsr;
  logic       serial_tx_active, osc_select, wake_pulse, ctrl_channel_ready, low_power;
  logic       mod_tick, rd_d;
  logic [7:0] exp_q[$];
  int         errors, compares, period, div;

  link_startup_ctrl #(.WAKE_HOLD_CYCLES(HOLD), .WAKE_IDLE_CYCLES(IDLE)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .power_down_n(power_down_n),
    .autostart_select_n(autostart_select_n), .controller_side_select(controller_side_select),
    .rate_doubling_pin(rate_doubling_pin), .lvds_clock_stable(lvds_clock_stable),
    .pll_lock(pll_lock), .modulation_coefficient(modulation_coefficient), .wake_rx(wake_rx),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_tx_active(serial_tx_active), .osc_select(osc_select),
    .wake_pulse(wake_pulse), .ctrl_channel_ready(ctrl_channel_ready),
    .low_power(low_power), .mod_tick(mod_tick));

  remote_ctrl_model partner_u (.ref_clk(ref_clk), .wake_pulse(wake_pulse),
    .link_active(serial_tx_active), .wake_rx(wake_rx));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // Waits n edges, then half a cycle more so registered outputs have settled.
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // The expected value is queued here and compared by the monitor two cycles later.
  task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : reg_read

  // Straps only change under power-down so the release edge captures them.
  task automatic restrap(input logic auto_n, input logic side, input logic dbl);
    @(posedge ref_clk);
    power_down_n <= 1'b0;
    settle(3);
    check("low_power", {7'h00, low_power}, 8'h01);
    @(posedge ref_clk);
    autostart_select_n <= auto_n;
    controller_side_select <= side;
    rate_doubling_pin <= dbl;
    pll_lock <= 1'b0;
    @(posedge ref_clk);
    power_down_n <= 1'b1;
  endtask : restrap

  task automatic tick_period(output int n);
    for (int i = 0; i < 1000 && mod_tick !== 1'b1; i++) @(posedge ref_clk);
    @(posedge ref_clk);
    n = 1;
    while (mod_tick !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : tick_period

  ////////////////////////////////////////////////////////////////////////////////
  // Read data stand only in the cycle after the strobe, so they are taken then.
  always @(posedge ref_clk) begin
    if (rd_d === 1'b1) begin
      check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
    rd_d <= reg_rd;
  end

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // The whole run needs at most about 2500 cycles; this limit leaves a wide margin.
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, power_down_n, lvds_clock_stable} = 3'b111;
    {autostart_select_n, controller_side_select, rate_doubling_pin, pll_lock} = 4'h0;
    {reg_wr, reg_rd, rd_d} = 3'b000;
    {reg_addr, reg_wdata} = 16'h0000;
    modulation_coefficient = COEF;
    lfsr = 8'h04;
    errors = 0;
    compares = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    settle(4);
    check("ctrl_channel_ready", {7'h00, ctrl_channel_ready}, 8'h00);
    @(posedge ref_clk);
    pll_lock <= 1'b1;
    settle(5);
    check("wake_count", 8'(partner_u.wake_count), 8'h01);
    check("remote_asleep", {7'h00, partner_u.remote_asleep}, 8'h00);
    check("serial_tx_active", {7'h00, serial_tx_active}, 8'h01);
    check("ctrl_channel_ready", {7'h00, ctrl_channel_ready}, 8'h01);
    reg_read(8'h05, 8'h0A);
    $display("Test autostart done");
    // Divider writes keep six bits; unmapped places hold nothing.
    repeat (3) begin
      lfsr = lfsr_next(lfsr);
      reg_write(8'h03, lfsr);
      reg_read(8'h03, lfsr & 8'h3F);
    end
    reg_write(8'h7E, 8'hFF);
    reg_read(8'h7E, 8'h00);
    reg_write(8'h04, 8'h07);
    reg_read(8'h04, 8'h03);
    settle(3);
    check("low_power", {7'h00, low_power}, 8'h00);
    $display("Test registers done");
    // A wrap of 250 to 500 cycles keeps the modulation within 20 to 40 kHz.
    div = 4 + int'(lfsr[0]);
    if (div > int'(SAWTOOTH_DIVIDER_MAX)) div = int'(SAWTOOTH_DIVIDER_MAX);
    reg_write(8'h03, 8'(div));
    // The accumulator may sit above the new wrap point and tick back to back at first.
    settle(20);
    tick_period(period);
    check("tick_period_lo", 8'(period), 8'(int'(COEF) * div));
    check("tick_period_hi", 8'(period >> 8), 8'((int'(COEF) * div) >> 8));
    $display("Test modulation done");
    reg_write(8'h04, 8'h02);
    settle(6);
    check("osc_select", {7'h00, osc_select}, 8'h01);
    check("serial_tx_active", {7'h00, serial_tx_active}, 8'h01);
    reg_write(8'h04, 8'h03);
    settle(6);
    check("osc_select", {7'h00, osc_select}, 8'h00);
    check("serial_tx_active", {7'h00, serial_tx_active}, 8'h01);
    $display("Test config link done");
    restrap(1'b1, 1'b1, 1'b0);
    settle(3);
    check("low_power", {7'h00, low_power}, 8'h01);
    check("remote_asleep", {7'h00, partner_u.remote_asleep}, 8'h01);
    reg_read(8'h04, 8'h04);
    partner_u.send_frame(8'h66);
    settle(2);
    check("low_power", {7'h00, low_power}, 8'h00);
    settle(HOLD + 40);
    check("low_power", {7'h00, low_power}, 8'h01);
    partner_u.send_frame(8'h66);
    pll_lock <= 1'b1;
    repeat (50) @(posedge ref_clk);
    reg_write(8'h04, 8'h01);
    settle(HOLD + 40);
    check("low_power", {7'h00, low_power}, 8'h00);
    check("serial_tx_active", {7'h00, serial_tx_active}, 8'h01);
    reg_write(8'h04, 8'h05);
    settle(3);
    check("low_power", {7'h00, low_power}, 8'h01);
    reg_read(8'h04, 8'h05);
    $display("Test remote sleep done");
    restrap(1'b1, 1'b0, 1'b0);
    settle(3);
    check("serial_tx_active", {7'h00, serial_tx_active}, 8'h00);
    check("low_power", {7'h00, low_power}, 8'h00);
    reg_read(8'h04, 8'h00);
    restrap(1'b0, 1'b0, 1'b1);
    @(posedge ref_clk);
    pll_lock <= 1'b1;
    settle(6);
    check("serial_tx_active", {7'h00, serial_tx_active}, 8'h01);
    check("low_power", {7'h00, low_power}, 8'h00);
    reg_read(8'h05, 8'h4A);
    // Doubling halves the wrap time, so twice the divider keeps the same period.
    reg_write(8'h03, 8'(2 * div));
    settle(20);
    tick_period(period);
    check("tick_period_lo", 8'(period), 8'(int'(COEF) * div));
    check("tick_period_hi", 8'(period >> 8), 8'((int'(COEF) * div) >> 8));
    $display("Test power-down release done");
    settle(4);
    print_verdict();
  end
endmodule : link_startup_ctrl_tb
